// ---- led_matrix_pkg.sv ----
// Purpose: Shared constants for the LED matrix PWM core and its host controller.
// Assumes: One 200 MHz clock; a single register request outstanding at a time.
// Notes: Device register indices and host register byte offsets live here.
package led_matrix_pkg;
  localparam int NUM_CH = 12;
  localparam int CNT_W = 10;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;
  localparam logic [CNT_W-1:0] CNT_MAX = 10'h3ff;
  localparam logic [CNT_W-1:0] CNT_RESET = 10'h000;
  localparam logic [CNT_W-1:0] CNT_HALF = 10'h200;
  // Device register indices.
  localparam logic [ADDR_W-1:0] REG_ON_BASE = 5'h00;
  localparam logic [ADDR_W-1:0] REG_OFF_BASE = 5'h0c;
  localparam logic [ADDR_W-1:0] REG_ENABLE = 5'h18;
  localparam logic [ADDR_W-1:0] REG_DIVIDER = 5'h19;
  localparam logic [ADDR_W-1:0] REG_SYSTEM_CONFIG_REGISTER = 5'h1a;
  localparam logic [ADDR_W-1:0] REG_FAULT = 5'h1b;
  // Divider setting: [2:0] power-of-two exponent, [7:3] count divider minus one.
  localparam int DIV_EXP_LSB = 0;
  localparam int DIV_EXP_W = 3;
  localparam int DIV_CNT_LSB = 3;
  localparam int DIV_CNT_W = 5;
  localparam logic [7:0] DIVIDER_RESET = 8'h04;
  localparam int SYSTEM_CONFIG_REGISTER_MASTER_BIT = 0;
  localparam int PRE_W = 7;
  // Host register byte offsets.
  localparam logic [7:0] HOST_DATA = 8'h00;
  localparam logic [7:0] HOST_CMD = 8'h04;
  localparam logic [7:0] HOST_STATUS = 8'h08;
  localparam logic [7:0] HOST_RDATA = 8'h0c;
  localparam logic [7:0] HOST_ALIGN = 8'h10;
  localparam int CMD_WRITE_BIT = 8;
  localparam int CMD_SYNC_BIT = 9;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : led_matrix_pkg

// ---- led_matrix_link.sv ----
// Purpose: Carrier between the host controller and one LED matrix core.
// Assumes: Both ends share aclk; the alignment line has a pull-down.
// Notes: The alignment line level is resolved here from both drivers.
`timescale 1ns/1ps
interface led_matrix_link;
  import led_matrix_pkg::*;
  logic req_valid;
  logic req_write;
  logic [ADDR_W-1:0] req_addr;
  logic [DATA_W-1:0] req_wdata;
  logic resp_valid;
  logic [DATA_W-1:0] resp_data;
  logic sync_cmd;
  logic host_align_out;
  logic host_align_oe_n;
  logic dev_align_out;
  logic dev_align_oe_n;
  logic align_line;

  // Undriven line reads low through the pull-down.
  assign align_line = (~host_align_oe_n & host_align_out) | (~dev_align_oe_n & dev_align_out);

  modport device_end (
    input req_valid, req_write, req_addr, req_wdata, sync_cmd, align_line,
    output resp_valid, resp_data, dev_align_out, dev_align_oe_n
  );
  modport host_end (
    output req_valid, req_write, req_addr, req_wdata, sync_cmd, host_align_out, host_align_oe_n,
    input resp_valid, resp_data, align_line
  );
endinterface : led_matrix_link

// ---- led_matrix_pwm_fault_core.sv ----
// Purpose: Twelve-channel PWM bypass-switch core with alignment and LED fault latching.
// Assumes: Detector inputs are asynchronous; requests come one at a time from the host end.
// Notes: Register writes take effect at once; there is no shadow update.
// Function
// - Ten-bit PWM per channel, separate on/off counts.
// - Period counter wraps 0 to 1023 continuously.
// - Counter equals on count: bypass switch off.
// - Counter equals off count: bypass switch on.
// - One period is 1024 PWM clock ticks.
// - Compare enable gates each channel's matches.
// - PWM clock: power-of-two prescaler then count divider.
// - Divisor defaults to sixteen.
// - Period counter starts from zero.
// - Master drives half-period alignment pulse at wrap.
// - Follower resets counter, divider on line rise.
// - Exactly one alignment source in the system.
// - Host gives same clock and divider everywhere.
// - Broadcast sync resets counter and divider.
// - Open detect forces bypass on, latched.
// - Latch holds until later on-off cycle.
// - Open detect sets channel fault flag.
// - Writing flag zero clears latch and flag.
// - No short-check voltage by period end: flag.
// - Equal counts mean off; off wins.
// - Detected fault posts at the off count.
`timescale 1ns/1ps
module led_matrix_pwm_fault_core
  import led_matrix_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Link to host
  led_matrix_link.device_end link,
  // Switch drive and analog detectors
  output logic [NUM_CH-1:0] bypass_on,
  input wire logic [NUM_CH-1:0] open_detect,
  input wire logic [NUM_CH-1:0] short_volt_ok
);

  logic [CNT_W-1:0] on_count [NUM_CH];
  logic [CNT_W-1:0] off_count [NUM_CH];
  logic [NUM_CH-1:0] compare_enable;
  logic [7:0] divider_setting;
  logic align_master;
  logic [NUM_CH-1:0] fault_flag;
  logic [NUM_CH-1:0] fault_clear;
  logic [CNT_W-1:0] pwm_period_counter;
  logic [CNT_W-1:0] next_count;
  logic [PRE_W-1:0] pre_cnt;
  logic [DIV_CNT_W-1:0] div_cnt;
  logic pre_wrap;
  logic pwm_tick;
  logic period_wrap;
  logic align_meta;
  logic align_sync;
  logic align_prev;
  logic align_rise;
  logic restart;
  logic [NUM_CH-1:0] open_meta;
  logic [NUM_CH-1:0] open_sync;
  logic [NUM_CH-1:0] short_meta;
  logic [NUM_CH-1:0] short_sync;
  logic [NUM_CH-1:0] next_flag;

  function automatic logic [PRE_W-1:0] prescale_last(input logic [7:0] setting);
    prescale_last = PRE_W'((1 << setting[DIV_EXP_LSB +: DIV_EXP_W]) - 1);
  endfunction : prescale_last

  function automatic logic is_reg(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] base, input int ch);
    is_reg = (addr == ADDR_W'(base + ADDR_W'(ch)));
  endfunction : is_reg

  // Detector and alignment inputs cross into aclk through two flops.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      open_meta <= '0;
      open_sync <= '0;
      short_meta <= '0;
      short_sync <= '0;
      align_meta <= 1'b0;
      align_sync <= 1'b0;
      align_prev <= 1'b0;
    end else begin
      open_meta <= open_detect;
      open_sync <= open_meta;
      short_meta <= short_volt_ok;
      short_sync <= short_meta;
      align_meta <= link.align_line;
      align_sync <= align_meta;
      align_prev <= align_sync;
    end
  end

  assign align_rise = align_sync & ~align_prev & ~align_master;
  assign restart = align_rise | link.sync_cmd;

  // Register writes from the host.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < NUM_CH; i++) begin
        on_count[i] <= CNT_RESET;
        off_count[i] <= CNT_RESET;
      end
      compare_enable <= '0;
      divider_setting <= DIVIDER_RESET;
      align_master <= 1'b0;
    end else if (link.req_valid && link.req_write) begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (is_reg(link.req_addr, REG_ON_BASE, i)) begin
          on_count[i] <= link.req_wdata[CNT_W-1:0];
        end
        if (is_reg(link.req_addr, REG_OFF_BASE, i)) begin
          off_count[i] <= link.req_wdata[CNT_W-1:0];
        end
      end
      if (link.req_addr == REG_ENABLE) begin
        compare_enable <= link.req_wdata[NUM_CH-1:0];
      end
      if (link.req_addr == REG_DIVIDER) begin
        divider_setting <= link.req_wdata[7:0];
      end
      if (link.req_addr == REG_SYSTEM_CONFIG_REGISTER) begin
        align_master <= link.req_wdata[SYSTEM_CONFIG_REGISTER_MASTER_BIT];
      end
    end
  end

  // A write of zero to a flag bit asks for that channel's flag and latch to clear.
  assign fault_clear = (link.req_valid && link.req_write && link.req_addr == REG_FAULT) ?
                       ~link.req_wdata[NUM_CH-1:0] : '0;

  // Read answers one cycle after the request.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link.resp_valid <= 1'b0;
      link.resp_data <= '0;
    end else begin
      link.resp_valid <= link.req_valid & ~link.req_write;
      if (link.req_valid && !link.req_write) begin
        link.resp_data <= '0;
        for (int i = 0; i < NUM_CH; i++) begin
          if (is_reg(link.req_addr, REG_ON_BASE, i)) begin
            link.resp_data <= DATA_W'(on_count[i]);
          end
          if (is_reg(link.req_addr, REG_OFF_BASE, i)) begin
            link.resp_data <= DATA_W'(off_count[i]);
          end
        end
        case (link.req_addr)
          REG_ENABLE: link.resp_data <= DATA_W'(compare_enable);
          REG_DIVIDER: link.resp_data <= DATA_W'(divider_setting);
          REG_SYSTEM_CONFIG_REGISTER: link.resp_data <= DATA_W'(align_master);
          REG_FAULT: link.resp_data <= DATA_W'(fault_flag);
          default: ;
        endcase
      end
    end
  end

  // Prescaler then count divider; the tick fires when both wrap together.
  assign pre_wrap = (pre_cnt == prescale_last(divider_setting));
  assign pwm_tick = pre_wrap && (div_cnt == divider_setting[DIV_CNT_LSB +: DIV_CNT_W]);
  assign period_wrap = pwm_tick && (pwm_period_counter == CNT_MAX);
  assign next_count = pwm_period_counter + 10'h001;

  always_ff @(posedge aclk) begin
    if (!aresetn || restart) begin
      pre_cnt <= '0;
      div_cnt <= '0;
    end else if (pre_wrap) begin
      pre_cnt <= '0;
      div_cnt <= pwm_tick ? '0 : div_cnt + 5'h01;
    end else begin
      pre_cnt <= pre_cnt + 7'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || restart) begin
      pwm_period_counter <= CNT_RESET;
    end else if (pwm_tick) begin
      pwm_period_counter <= next_count;
    end
  end

  // Master drives the line high for the first half of each period.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link.dev_align_out <= 1'b0;
      link.dev_align_oe_n <= 1'b1;
    end else begin
      link.dev_align_oe_n <= ~align_master;
      if (period_wrap) begin
        link.dev_align_out <= align_master;
      end else if (pwm_tick && next_count == CNT_HALF) begin
        link.dev_align_out <= 1'b0;
      end
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_chan
      logic lit;
      logic forced;
      logic seen_on;
      logic pending;
      logic lit_cycle;
      logic volt_seen;
      logic on_hit;
      logic off_hit;
      logic open_hit;
      logic short_hit;
      logic next_lit;
      logic next_forced;

      // Compare against the value the counter is about to take.
      assign on_hit = pwm_tick && compare_enable[ch] && next_count == on_count[ch];
      assign off_hit = pwm_tick && compare_enable[ch] && next_count == off_count[ch];
      assign open_hit = lit && !forced && open_sync[ch];
      assign short_hit = period_wrap && lit_cycle && !volt_seen;
      assign next_lit = off_hit ? 1'b0 : (on_hit ? 1'b1 : lit);
      // New detection wins over any clear in the same cycle.
      assign next_forced = open_hit ? 1'b1 :
                           ((fault_clear[ch] || (forced && seen_on && off_hit)) ? 1'b0 : forced);
      assign next_flag[ch] = (off_hit && (pending || open_hit)) ? 1'b1 :
                             (fault_clear[ch] ? 1'b0 : fault_flag[ch]);

      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          lit <= 1'b0;
          forced <= 1'b0;
          bypass_on[ch] <= 1'b1;
        end else begin
          lit <= next_lit;
          forced <= next_forced;
          bypass_on[ch] <= ~next_lit | next_forced;
        end
      end

      // Besides a flag clear, the latch only releases after an on match followed by an off match.
      always_ff @(posedge aclk) begin
        if (!aresetn || open_hit || fault_clear[ch]) begin
          seen_on <= 1'b0;
        end else if (forced && on_hit) begin
          seen_on <= 1'b1;
        end
      end

      // A fault found mid-period waits here until the off count.
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          pending <= 1'b0;
        end else if (open_hit || short_hit) begin
          pending <= 1'b1;
        end else if (off_hit) begin
          pending <= 1'b0;
        end
      end

      // Short check: lit at some point in the period without the detector seeing voltage.
      always_ff @(posedge aclk) begin
        if (!aresetn || period_wrap) begin
          lit_cycle <= 1'b0;
          volt_seen <= 1'b0;
        end else begin
          lit_cycle <= lit_cycle | (lit & ~forced);
          volt_seen <= volt_seen | (lit & short_sync[ch]);
        end
      end
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fault_flag <= '0;
    end else begin
      fault_flag <= next_flag;
    end
  end

endmodule : led_matrix_pwm_fault_core

// ---- led_matrix_host.sv ----
// Purpose: Host end: AXI4-Lite registers turned into link requests and alignment drive.
// Assumes: Software issues one link command at a time and polls busy.
// Notes: Broadcast sync is a one-cycle pulse on the link, no request.
`timescale 1ns/1ps
module led_matrix_host
  import led_matrix_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write channels
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Link to device
  led_matrix_link.host_end link
);

  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [DATA_W-1:0] cmd_data;
  logic [DATA_W-1:0] read_data;
  logic busy;
  logic do_write;

  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign do_write = aw_held & w_held;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr > HOST_ALIGN || aw_addr[1:0] != 2'h0) ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Link commands; a command written while busy is dropped.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmd_data <= '0;
      busy <= 1'b0;
      read_data <= '0;
      link.req_valid <= 1'b0;
      link.req_write <= 1'b0;
      link.req_addr <= '0;
      link.req_wdata <= '0;
      link.sync_cmd <= 1'b0;
      link.host_align_out <= 1'b0;
      link.host_align_oe_n <= 1'b1;
    end else begin
      link.req_valid <= 1'b0;
      link.sync_cmd <= 1'b0;
      if (link.resp_valid) begin
        read_data <= link.resp_data;
        busy <= 1'b0;
      end
      if (link.req_valid && link.req_write) begin
        busy <= 1'b0;
      end
      if (do_write && aw_addr == HOST_DATA && s_axi_wstrb != 4'h0) begin
        cmd_data <= w_data[DATA_W-1:0];
      end
      if (do_write && aw_addr == HOST_CMD && !busy) begin
        if (w_data[CMD_SYNC_BIT]) begin
          link.sync_cmd <= 1'b1;
        end else begin
          link.req_valid <= 1'b1;
          link.req_write <= w_data[CMD_WRITE_BIT];
          link.req_addr <= w_data[ADDR_W-1:0];
          link.req_wdata <= cmd_data;
          busy <= 1'b1;
        end
      end
      // Software must leave drive off when a device is the alignment master.
      if (do_write && aw_addr == HOST_ALIGN) begin
        link.host_align_out <= w_data[0];
        link.host_align_oe_n <= ~w_data[1];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      case (s_axi_araddr)
        HOST_DATA: s_axi_rdata <= 32'(cmd_data);
        HOST_CMD: s_axi_rdata <= 32'h00000000;
        HOST_STATUS: s_axi_rdata <= {30'h00000000, link.align_line, busy};
        HOST_RDATA: s_axi_rdata <= 32'(read_data);
        HOST_ALIGN: s_axi_rdata <= {30'h00000000, ~link.host_align_oe_n, link.host_align_out};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : led_matrix_host

// ---- led_matrix_link_sva.sv ----
// Purpose: Link-side checks between the host end and the LED matrix core.
// Assumes: One clock; the host end is the only other alignment driver.
// Notes: Pulse checks skip any pulse disturbed by a restart or a divisor change.
`timescale 1ns/1ps
module led_matrix_link_sva
  import led_matrix_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Request and answer
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  input wire logic resp_valid,
  input wire logic [DATA_W-1:0] resp_data,
  // Alignment
  input wire logic sync_cmd,
  input wire logic host_align_oe_n,
  input wire logic dev_align_out,
  input wire logic dev_align_oe_n
);
  int unsigned div;
  int unsigned hi_cnt;
  int unsigned per_cnt;
  logic out_q;
  logic clean;
  logic wr_div;
  logic rise;
  logic upset;

  assign wr_div = req_valid && req_write && req_addr == REG_DIVIDER;
  assign rise = dev_align_out && !out_q;
  // A restart or a new divisor makes the pulse in flight meaningless, so it is not judged.
  assign upset = wr_div || sync_cmd || !host_align_oe_n || (req_valid && req_write && req_addr == REG_SYSTEM_CONFIG_REGISTER);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div <= 16;
    end else if (wr_div) begin
      div <= (32'h1 << req_wdata[2:0]) * (32'(req_wdata[7:3]) + 1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_q <= 1'b0;
      hi_cnt <= 0;
      per_cnt <= 0;
      clean <= 1'b0;
    end else begin
      out_q <= dev_align_out;
      hi_cnt <= dev_align_out ? hi_cnt + 1 : 0;
      per_cnt <= rise ? 1 : per_cnt + 1;
      clean <= !upset && (rise || clean);
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_read_answer: assert property (req_valid && !req_write |=> resp_valid)
    else $error("read request got no answer next cycle");
  chk_answer_cause: assert property (resp_valid |-> $past(req_valid && !req_write))
    else $error("answer without a read request");
  chk_write_silent: assert property (req_valid && req_write |=> !resp_valid)
    else $error("write request was answered");
  chk_data_hold: assert property (!resp_valid |-> $stable(resp_data))
    else $error("read data moved without an answer");
  chk_sync_pulse: assert property (sync_cmd |=> !sync_cmd)
    else $error("sync pulse longer than one cycle");
  chk_one_source: assert property (!(!host_align_oe_n && !dev_align_oe_n))
    else $error("two drivers on the alignment line");
  chk_pulse_width: assert property (!dev_align_out && out_q && clean |-> hi_cnt == 512 * div)
    else $error("alignment pulse is not half a period");
  chk_pulse_period: assert property (rise && clean |-> per_cnt == 1024 * div)
    else $error("alignment pulses not one period apart");

  cov_pulse: cover property (rise && clean);
  cov_read: cover property (resp_valid);
  cov_sync: cover property (sync_cmd);
  cov_host_drive: cover property (!host_align_oe_n);
endmodule : led_matrix_link_sva

// ---- led_matrix_pwm_fault_core_tb.sv ----
// Purpose: Self-checking bench joining the host end and the LED matrix core.
// Assumes: Detector inputs are driven directly as comparator levels.
// Notes: Expected counts come from the programmed values, never from the design.
`timescale 1ns/1ps
module led_matrix_pwm_fault_core_tb
  import led_matrix_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, r;
  logic [NUM_CH-1:0] bypass_on;
  logic [NUM_CH-1:0] open_detect = 12'h000;
  logic [NUM_CH-1:0] short_volt_ok = 12'hfff;
  logic [9:0] on_c [NUM_CH];
  logic [9:0] off_c [NUM_CH];
  logic [ADDR_W-1:0] zero_regs [4] = '{REG_ENABLE, REG_SYSTEM_CONFIG_REGISTER, REG_FAULT, 5'h1f};
  int n_fail = 0;
  int n_tests = 0;
  int lo_cnt [NUM_CH];
  int al_cnt, dv, ex, cx, n;

  always #2.5 aclk = ~aclk;

  led_matrix_link link ();
  led_matrix_host i_led_matrix_host (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .link(link));
  led_matrix_pwm_fault_core i_led_matrix_pwm_fault_core (.aclk(aclk), .aresetn(aresetn), .link(link),
    .bypass_on(bypass_on), .open_detect(open_detect), .short_volt_ok(short_volt_ok));
  led_matrix_link_sva i_led_matrix_link_sva (.aclk(aclk), .aresetn(aresetn),
    .req_valid(link.req_valid), .req_write(link.req_write), .req_addr(link.req_addr),
    .req_wdata(link.req_wdata), .resp_valid(link.resp_valid), .resp_data(link.resp_data),
    .sync_cmd(link.sync_cmd), .host_align_oe_n(link.host_align_oe_n),
    .dev_align_out(link.dev_align_out), .dev_align_oe_n(link.dev_align_oe_n));

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  function automatic logic [31:0] lit_cycles(input logic [9:0] on, input logic [9:0] off);
    lit_cycles = 32'(10'(off - on));
  endfunction : lit_cycles

  // Handshakes are judged at the falling edge, where ready has settled for the next rising edge.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
    logic aw_t, w_t, b_t;
    b_t = 1'b0;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b_t) begin
      @(negedge aclk);
      aw_t = awvalid && awready;
      w_t = wvalid && wready;
      b_t = bvalid === 1'b1;
      resp = bresp;
      @(posedge aclk);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    @(posedge aclk);
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
    logic ar_t, r_t;
    r_t = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!r_t) begin
      @(negedge aclk);
      ar_t = arvalid && arready;
      r_t = rvalid === 1'b1;
      v = rdata;
      resp = rresp;
      @(posedge aclk);
      if (ar_t) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    @(posedge aclk);
  endtask : axi_rd

  task automatic wait_idle;
    do begin
      axi_rd(HOST_STATUS, d, r);
    end while (d[0] !== 1'b0);
  endtask : wait_idle

  task automatic dev_wr(input logic [ADDR_W-1:0] a, input logic [15:0] v);
    axi_wr(HOST_DATA, {16'h0000, v}, r);
    axi_wr(HOST_CMD, (32'h1 << CMD_WRITE_BIT) | 32'(a), r);
    wait_idle();
  endtask : dev_wr

  task automatic dev_rd(input logic [ADDR_W-1:0] a, output logic [31:0] v);
    axi_wr(HOST_CMD, 32'(a), r);
    wait_idle();
    axi_rd(HOST_RDATA, v, r);
  endtask : dev_rd

  task automatic count_window(input int cyc);
    lo_cnt = '{default: 0};
    al_cnt = 0;
    repeat (cyc) begin
      @(negedge aclk);
      for (int c = 0; c < NUM_CH; c++) begin
        lo_cnt[c] += int'(bypass_on[c] === 1'b0);
      end
      al_cnt += int'(link.align_line === 1'b1);
    end
    @(posedge aclk);
  endtask : count_window

  task automatic rise_delay(input int ch, output int cnt);
    logic prev, cur;
    cnt = 0;
    cur = bypass_on[ch];
    do begin
      prev = cur;
      @(negedge aclk);
      cnt++;
      cur = bypass_on[ch];
    end while (!(cur === 1'b1 && prev === 1'b0));
    @(posedge aclk);
  endtask : rise_delay

  task automatic print_verdict;
    $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict

  initial begin
    #500000;
    n_fail++;
    print_verdict();
  end

  initial begin
    void'($urandom(9675));
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    @(negedge aclk);
    check({20'h0, bypass_on}, 32'h00000fff, "dark after reset");
    @(posedge aclk);
    axi_rd(HOST_STATUS, d, r);
    check(d, 32'h0, "status after reset");
    axi_rd(8'h14, d, r);
    check(32'(r), 32'(RESP_SLVERR), "unmapped read");
    axi_wr(8'h02, 32'h1, r);
    check(32'(r), 32'(RESP_SLVERR), "misaligned write");
    dev_rd(REG_DIVIDER, d);
    check(d, 32'h4, "divider reset");
    foreach (zero_regs[i]) begin
      dev_rd(zero_regs[i], d);
      check(d, 32'h0, "register reset");
    end
    $display("test reset done");
    dev_wr(REG_SYSTEM_CONFIG_REGISTER, 16'h0001);
    repeat (16400) @(posedge aclk);
    count_window(16384);
    check(al_cnt, 8192, "master pulse at default divisor");
    ex = $urandom_range(0, 1);
    cx = $urandom_range(0, 3);
    dv = (1 << ex) * (cx + 1);
    dev_wr(REG_DIVIDER, 16'(cx * 8 + ex));
    repeat (1024 * dv + 16) @(posedge aclk);
    count_window(1024 * dv);
    check(al_cnt, 512 * dv, "master pulse");
    dev_wr(REG_SYSTEM_CONFIG_REGISTER, 16'h0000);
    $display("test master done");
    dev_wr(REG_DIVIDER, 16'h0000);
    for (int c = 0; c < NUM_CH; c++) begin
      on_c[c] = 10'($urandom_range(0, 1023));
      off_c[c] = 10'($urandom_range(0, 1023));
    end
    off_c[0] = on_c[0];
    on_c[2] = 10'h3ff;
    off_c[2] = 10'h000;
    for (int c = 0; c < NUM_CH; c++) begin
      dev_wr(REG_ON_BASE + 5'(c), 16'(on_c[c]));
      dev_wr(REG_OFF_BASE + 5'(c), 16'(off_c[c]));
    end
    dev_rd(REG_OFF_BASE + 5'h05, d);
    check(d, 32'(off_c[5]), "count readback");
    dev_wr(REG_ENABLE, 16'h0ffd);
    repeat (2100) @(posedge aclk);
    count_window(1024);
    for (int c = 0; c < NUM_CH; c++) begin
      check(lo_cnt[c], (c == 1) ? 32'h0 : lit_cycles(on_c[c], off_c[c]), "lit cycles");
    end
    $display("test pwm done");
    dev_wr(REG_ON_BASE + 5'h05, 16'h00c8);
    dev_wr(REG_OFF_BASE + 5'h05, 16'h012c);
    repeat (1100) @(posedge aclk);
    axi_wr(HOST_CMD, 32'h1 << CMD_SYNC_BIT, r);
    rise_delay(5, n);
    check(32'(n >= 290 && n <= 306), 32'h1, "restart by sync");
    repeat (400) @(posedge aclk);
    axi_wr(HOST_ALIGN, 32'h3, r);
    rise_delay(5, n);
    check(32'(n >= 290 && n <= 306), 32'h1, "restart by line");
    axi_wr(HOST_ALIGN, 32'h0, r);
    $display("test restart done");
    for (int c = 3; c < 5; c++) begin
      dev_wr(REG_ON_BASE + 5'(c), 16'h0064);
      dev_wr(REG_OFF_BASE + 5'(c), 16'h0258);
    end
    repeat (1100) @(posedge aclk);
    do @(negedge aclk); while (bypass_on[3] !== 1'b0);
    @(posedge aclk);
    open_detect <= 12'h008;
    short_volt_ok <= 12'hfef;
    repeat (6) @(negedge aclk);
    check(32'(bypass_on[3]), 32'h1, "open forces bypass");
    @(posedge aclk);
    repeat (3100) @(posedge aclk);
    dev_rd(REG_FAULT, d);
    check(d, 32'h18, "fault flags");
    open_detect <= 12'h000;
    short_volt_ok <= 12'hfff;
    repeat (2100) @(posedge aclk);
    dev_wr(REG_FAULT, 16'h0000);
    dev_rd(REG_FAULT, d);
    check(d, 32'h0, "flags cleared");
    repeat (1100) @(posedge aclk);
    count_window(1024);
    check(lo_cnt[3], 500, "open channel lit again");
    check(lo_cnt[4], 500, "short channel lit again");
    $display("test fault done");
    print_verdict();
  end
endmodule : led_matrix_pwm_fault_core_tb
